// file: pwn_pkg.sv
package pwn_pkg;

	// Object dictionary indices
	localparam logic [15:0] OBJ_CMD_POS = 16'h6062;
	localparam logic [15:0] OBJ_MEAS_INT = 16'h6063;
	localparam logic [15:0] OBJ_MEAS_POS = 16'h6064;
	localparam logic [15:0] OBJ_LAG_LIMIT = 16'h6065;
	localparam logic [15:0] OBJ_LAG_TMO = 16'h6066;
	localparam logic [15:0] OBJ_ARR_BAND = 16'h6067;
	localparam logic [15:0] OBJ_ARR_DWELL = 16'h6068;
	localparam logic [15:0] OBJ_SPEED = 16'h60fa;

	// Reset values of the writable objects, and the largest lag limit accepted
	localparam logic [31:0] RST_LAG_LIMIT = 32'h0000_7530;
	localparam logic [15:0] RST_LAG_TMO = 16'h00c8;
	localparam logic [31:0] RST_ARR_BAND = 32'h0000_000a;
	localparam logic [15:0] RST_ARR_DWELL = 16'h0032;
	localparam logic [31:0] MAX_LAG_LIMIT = 32'h7fff_ffff;

	// State report bit positions
	localparam int BIT_ARRIVED = 10;
	localparam int BIT_LAG_FAULT = 13;

	// Loop gain is unsigned with this many fraction bits
	localparam int GAIN_FRAC = 8;

	// Millisecond tick derived from the 200 MHz clock
	localparam int CLK_PERIOD_PS = 5000;
	localparam int TICK_TIME_PS = 1000000000;
	localparam int TICK_CYCLES = TICK_TIME_PS / CLK_PERIOD_PS;

	typedef enum logic [3:0] {
		SEL_NONE = 4'b0000,
		SEL_CMD_POS = 4'b0001,
		SEL_MEAS_INT = 4'b0010,
		SEL_MEAS_POS = 4'b0011,
		SEL_LAG_LIMIT = 4'b0100,
		SEL_LAG_TMO = 4'b0101,
		SEL_ARR_BAND = 4'b0110,
		SEL_ARR_DWELL = 4'b0111,
		SEL_SPEED = 4'b1000
	} pwn_sel_e;

	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] index;
		logic [31:0] wdata;
	} pwn_obj_req_s;

	typedef struct packed {
		logic ack;
		logic err;
		logic [31:0] rdata;
	} pwn_obj_rsp_s;

endpackage

// file: pwn_scaler.sv
`timescale 1ns/1ps
`default_nettype none
module pwn_scaler (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic signed [31:0] internal_i,
	input wire logic [31:0] num_i,
	input wire logic [31:0] div_i,
	output logic signed [31:0] user_o
);
	import pwn_pkg::*;

	logic signed [64:0] prod;
	logic signed [64:0] quo;
	logic signed [31:0] user_d;
	logic signed [31:0] user_q;

	// A zero numerator would divide by zero, so the value passes unscaled
	always_comb begin
		prod = 65'(internal_i) * $signed({33'h0, div_i});
		quo = (num_i == 32'h0) ? 65'(internal_i) : prod / $signed({33'h0, num_i});
		user_d = quo[31:0];
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			user_q <= 32'sh0;
		end else begin
			user_q <= user_d;
		end
	end

	assign user_o = user_q;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);

	a_unit_factor: assert property ((num_i == div_i) && (num_i != 32'h0) |=>
		user_q == $past(internal_i)) else $error("Unit factor changed the position");
endmodule
`default_nettype wire

// file: pwn_band_timer.sv
`timescale 1ns/1ps
`default_nettype none
module pwn_band_timer #(
	parameter bit COUNT_INSIDE = 1'b1
) (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic tick_i,
	input wire logic [32:0] dist_i,
	input wire logic [31:0] band_i,
	input wire logic [15:0] limit_i,
	output logic flag_o
);
	import pwn_pkg::*;

	logic in_band;
	logic cond;
	logic [15:0] cnt_d;
	logic [15:0] cnt_q;
	logic flag_d;
	logic flag_q;

	// Ticks are not aligned to band entry, so the wait is limit-1 to limit ms
	always_comb begin
		in_band = dist_i <= {1'b0, band_i};
		cond = COUNT_INSIDE ? in_band : !in_band;
		if (!cond) begin
			cnt_d = 16'h0;
		end else if (tick_i && cnt_q != 16'hffff) begin
			cnt_d = cnt_q + 16'h1;
		end else begin
			cnt_d = cnt_q;
		end
		flag_d = cond && (cnt_d >= limit_i);
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_q <= 16'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

	assign flag_o = flag_q;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);

	sequence s_left_condition;
		!cond;
	endsequence

	a_flag_drops_now: assert property (s_left_condition |=> !flag_q)
		else $error("Flag stayed up after the band condition ended");
	a_flag_needs_time: assert property ($rose(flag_q) |-> $past(cond) &&
		($past(cnt_q) >= $past(limit_i) || $past(tick_i)))
		else $error("Flag rose before the time had run");
	a_timer_restarts: assert property (s_left_condition |=> cnt_q == 16'h0)
		else $error("Timer kept counting outside its condition");
endmodule
`default_nettype wire

// file: pwn_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pwn_monitor #(
	parameter int TICK_CYCLES = pwn_pkg::TICK_CYCLES
) (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic signed [31:0] cmd_pos_i,
	input wire logic signed [31:0] target_pos_i,
	input wire logic signed [31:0] enc_pos_i,
	input wire logic [31:0] fac_num_i,
	input wire logic [31:0] fac_div_i,
	input wire logic [15:0] loop_gain_i,
	input wire logic [31:0] speed_limit_i,
	input wire pwn_pkg::pwn_obj_req_s obj_req_i,
	output pwn_pkg::pwn_obj_rsp_s obj_rsp_o,
	output logic signed [31:0] speed_cmd_o,
	output logic lag_fault_o,
	output logic arrived_o,
	output logic [15:0] status_bits_o
);
	import pwn_pkg::*;

	function automatic pwn_sel_e decode_index(input logic [15:0] idx);
		unique case (idx)
			OBJ_CMD_POS: decode_index = SEL_CMD_POS;
			OBJ_MEAS_INT: decode_index = SEL_MEAS_INT;
			OBJ_MEAS_POS: decode_index = SEL_MEAS_POS;
			OBJ_LAG_LIMIT: decode_index = SEL_LAG_LIMIT;
			OBJ_LAG_TMO: decode_index = SEL_LAG_TMO;
			OBJ_ARR_BAND: decode_index = SEL_ARR_BAND;
			OBJ_ARR_DWELL: decode_index = SEL_ARR_DWELL;
			OBJ_SPEED: decode_index = SEL_SPEED;
			default: decode_index = SEL_NONE;
		endcase
	endfunction

	function automatic logic [32:0] magnitude(input logic signed [32:0] v);
		magnitude = v[32] ? 33'(-v) : 33'(v);
	endfunction

	// Parameter objects
	logic [31:0] lag_limit_q;
	logic [15:0] lag_tmo_q;
	logic [31:0] arr_band_q;
	logic [15:0] arr_dwell_q;

	// Loop datapath
	logic signed [31:0] cmd_pos_q;
	logic signed [31:0] target_q;
	logic signed [31:0] enc_pos_q;
	logic signed [31:0] meas_pos;
	logic signed [32:0] ferr_d;
	logic signed [32:0] ferr_q;
	logic [32:0] ferr_mag;
	logic [32:0] arr_dist;
	logic signed [49:0] effort_raw;
	logic signed [49:0] effort_shift;
	logic signed [49:0] lim_pos;
	logic signed [31:0] speed_d;
	logic signed [31:0] speed_q;

	// Millisecond tick
	logic [17:0] tick_cnt_q;
	logic tick_q;

	// Object access
	pwn_sel_e sel;
	logic wr_ok;
	logic wr_range_bad;
	pwn_obj_rsp_s rsp_d;
	pwn_obj_rsp_s rsp_q;

	logic lag_flag;
	logic arr_flag;

	// Reference and encoder sample; both arrive from logic on this clock
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cmd_pos_q <= 32'sh0;
			target_q <= 32'sh0;
			enc_pos_q <= 32'sh0;
		end else begin
			cmd_pos_q <= cmd_pos_i;
			target_q <= target_pos_i;
			enc_pos_q <= enc_pos_i;
		end
	end

	pwn_scaler u_scaler (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.internal_i(enc_pos_q),
		.num_i(fac_num_i),
		.div_i(fac_div_i),
		.user_o(meas_pos)
	);

	// Error is wider than a position so that no difference can wrap
	always_comb begin
		ferr_d = 33'(meas_pos) - 33'(cmd_pos_q);
		ferr_mag = magnitude(ferr_q);
		arr_dist = magnitude(33'(meas_pos) - 33'(target_q));
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ferr_q <= 33'sh0;
		end else begin
			ferr_q <= ferr_d;
		end
	end

	// Proportional loop; the loop drives the error toward zero
	always_comb begin
		effort_raw = -(50'(ferr_q) * $signed({34'h0, loop_gain_i}));
		effort_shift = effort_raw >>> GAIN_FRAC;
		lim_pos = $signed({18'h0, speed_limit_i});
		if (effort_shift > lim_pos) begin
			speed_d = lim_pos[31:0];
		end else if (effort_shift < -lim_pos) begin
			speed_d = 32'(-lim_pos);
		end else begin
			speed_d = effort_shift[31:0];
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			speed_q <= 32'sh0;
		end else begin
			speed_q <= speed_d;
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tick_cnt_q <= 18'h0;
			tick_q <= 1'b0;
		end else if (tick_cnt_q == 18'(TICK_CYCLES - 1)) begin
			tick_cnt_q <= 18'h0;
			tick_q <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 18'h1;
			tick_q <= 1'b0;
		end
	end

	pwn_band_timer #(
		.COUNT_INSIDE(1'b0)
	) u_lag_timer (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.tick_i(tick_q),
		.dist_i(ferr_mag),
		.band_i(lag_limit_q),
		.limit_i(lag_tmo_q),
		.flag_o(lag_flag)
	);

	pwn_band_timer #(
		.COUNT_INSIDE(1'b1)
	) u_arrival_timer (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.tick_i(tick_q),
		.dist_i(arr_dist),
		.band_i(arr_band_q),
		.limit_i(arr_dwell_q),
		.flag_o(arr_flag)
	);

	// Object access: answered one cycle after the request
	always_comb begin
		sel = decode_index(obj_req_i.index);
		wr_range_bad = (sel == SEL_LAG_LIMIT) && (obj_req_i.wdata > MAX_LAG_LIMIT);
		wr_ok = obj_req_i.valid && obj_req_i.write && !wr_range_bad &&
			(sel == SEL_LAG_LIMIT || sel == SEL_LAG_TMO ||
			sel == SEL_ARR_BAND || sel == SEL_ARR_DWELL);
		rsp_d.ack = obj_req_i.valid;
		rsp_d.err = obj_req_i.valid && (sel == SEL_NONE ||
			(obj_req_i.write && !wr_ok));
		rsp_d.rdata = 32'h0;
		if (obj_req_i.valid && !obj_req_i.write) begin
			unique case (sel)
				SEL_CMD_POS: rsp_d.rdata = cmd_pos_q;
				SEL_MEAS_INT: rsp_d.rdata = enc_pos_q;
				SEL_MEAS_POS: rsp_d.rdata = meas_pos;
				SEL_LAG_LIMIT: rsp_d.rdata = lag_limit_q;
				SEL_LAG_TMO: rsp_d.rdata = {16'h0, lag_tmo_q};
				SEL_ARR_BAND: rsp_d.rdata = arr_band_q;
				SEL_ARR_DWELL: rsp_d.rdata = {16'h0, arr_dwell_q};
				SEL_SPEED: rsp_d.rdata = speed_q;
				SEL_NONE: rsp_d.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rsp_q <= '0;
		end else begin
			rsp_q <= rsp_d;
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			lag_limit_q <= RST_LAG_LIMIT;
			lag_tmo_q <= RST_LAG_TMO;
			arr_band_q <= RST_ARR_BAND;
			arr_dwell_q <= RST_ARR_DWELL;
		end else if (wr_ok) begin
			unique case (sel)
				SEL_LAG_LIMIT: lag_limit_q <= obj_req_i.wdata;
				SEL_LAG_TMO: lag_tmo_q <= obj_req_i.wdata[15:0];
				SEL_ARR_BAND: arr_band_q <= obj_req_i.wdata;
				SEL_ARR_DWELL: arr_dwell_q <= obj_req_i.wdata[15:0];
				default: lag_limit_q <= lag_limit_q;
			endcase
		end
	end

	assign obj_rsp_o = rsp_q;
	assign speed_cmd_o = speed_q;
	assign lag_fault_o = lag_flag;
	assign arrived_o = arr_flag;

	always_comb begin
		status_bits_o = 16'h0;
		status_bits_o[BIT_LAG_FAULT] = lag_flag;
		status_bits_o[BIT_ARRIVED] = arr_flag;
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);

	sequence s_write_to(logic [15:0] idx);
		obj_req_i.valid && obj_req_i.write && obj_req_i.index == idx;
	endsequence

	a_obj_answer: assert property (obj_req_i.valid |=> obj_rsp_o.ack)
		else $error("Object request not answered in one cycle");
	a_ro_refused: assert property (s_write_to(OBJ_MEAS_POS) |=> obj_rsp_o.err)
		else $error("Write to a read-only object was accepted");
	a_lag_range: assert property (s_write_to(OBJ_LAG_LIMIT) &&
		obj_req_i.wdata > MAX_LAG_LIMIT |=> obj_rsp_o.err && $stable(lag_limit_q))
		else $error("Out of range lag limit was taken");
	a_error_diff: assert property (##1 ferr_q == 33'($past(meas_pos)) -
		33'($past(cmd_pos_q))) else $error("Following error is not actual minus command");
	a_speed_clamp: assert property (##1 speed_q <= $signed({1'b0, $past(speed_limit_i)}) &&
		speed_q >= -$signed({1'b0, $past(speed_limit_i)}))
		else $error("Speed command outside its limit");
	a_ref_follow: assert property (##2 cmd_pos_q == $past(cmd_pos_i, 1))
		else $error("Reference not taken from the trajectory input");
	a_tick_spacing: assert property (tick_q |=> !tick_q)
		else $error("Millisecond tick wider than one cycle");
	a_lag_bit: assert property ($rose(lag_fault_o) |->
		$past(ferr_mag) > {1'b0, $past(lag_limit_q)} && status_bits_o[BIT_LAG_FAULT])
		else $error("Lag fault without the error outside its band");
	a_arrival_out: assert property (##2 $past(arr_dist) > {1'b0, $past(arr_band_q)}
		|-> !arrived_o) else $error("Arrival flag held outside the band");
endmodule
`default_nettype wire

// file: pwn_partner.sv
`timescale 1ns/1ps
`default_nettype none
module pwn_partner (
	input wire logic sys_clk_i,
	input wire pwn_pkg::pwn_obj_rsp_s obj_rsp_i,
	output logic signed [31:0] enc_pos_o,
	output pwn_pkg::pwn_obj_req_s obj_req_o
);
	import pwn_pkg::*;

	initial begin
		enc_pos_o = '0;
		obj_req_o = '0;
	end

	task automatic set_enc(input logic signed [31:0] v);
		enc_pos_o = v;
	endtask

	// Request held until ack is seen or four edges have passed, then one idle edge so it is never re-raised at once
	task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] wd,
		output logic err, output logic [31:0] rd, output bit ok);
		ok = 0;
		obj_req_o = {1'b1, w, idx, wd};
		for (int i = 0; i < 4 && !ok; i++) begin
			@(posedge sys_clk_i);
			#1;
			ok = obj_rsp_i.ack;
		end
		err = obj_rsp_i.err;
		rd = obj_rsp_i.rdata;
		// Released fields show the inverse so stale values never look valid
		obj_req_o = {1'b0, ~w, ~idx, ~wd};
		@(posedge sys_clk_i);
		#1;
	endtask
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import pwn_pkg::*;
	localparam int TCK = 10;
	logic sys_clk_i, resetn_i, lag_fault, arrived;
	logic signed [31:0] cmd_pos, target_pos, enc_pos, speed_cmd;
	logic [31:0] fac_num, fac_div, speed_limit;
	logic [15:0] loop_gain, status_bits;
	pwn_obj_req_s obj_req;
	pwn_obj_rsp_s obj_rsp;
	int fail_count = 0;
	int n_checks = 0;

	pwn_monitor #(.TICK_CYCLES(TCK)) i_pwn_monitor (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
		.cmd_pos_i(cmd_pos), .target_pos_i(target_pos), .enc_pos_i(enc_pos),
		.fac_num_i(fac_num), .fac_div_i(fac_div), .loop_gain_i(loop_gain),
		.speed_limit_i(speed_limit), .obj_req_i(obj_req), .obj_rsp_o(obj_rsp),
		.speed_cmd_o(speed_cmd), .lag_fault_o(lag_fault), .arrived_o(arrived),
		.status_bits_o(status_bits));
	pwn_partner i_pwn_partner (.sys_clk_i(sys_clk_i), .obj_rsp_i(obj_rsp),
		.enc_pos_o(enc_pos), .obj_req_o(obj_req));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask

	task automatic acc(input logic w, input logic [15:0] idx, input logic [31:0] wd,
		input logic e, input logic [31:0] d);
		logic err;
		logic [31:0] rd;
		bit ok;
		i_pwn_partner.xfer(w, idx, wd, err, rd, ok);
		if (!ok) begin
			fail_count++;
			$display("mismatch ack %h expected 1 seen 0", idx);
			results;
		end
		check($sformatf("err %h", idx), {31'h0, err}, {31'h0, e});
		check($sformatf("data %h", idx), rd, d);
	endtask

	task automatic wait_bit(input int b, input logic v, input int lim, output int n);
		n = 0;
		while (status_bits[b] !== v && n < lim) begin
			cyc(1);
			n++;
		end
	endtask

	task automatic t_regs;
		logic [15:0] ro [4] = '{OBJ_CMD_POS, OBJ_MEAS_INT, OBJ_MEAS_POS, OBJ_SPEED};
		check("speed reset", speed_cmd, 32'h0);
		acc(0, OBJ_LAG_LIMIT, 0, 0, RST_LAG_LIMIT);
		acc(0, OBJ_LAG_TMO, 0, 0, {16'h0, RST_LAG_TMO});
		acc(0, OBJ_ARR_BAND, 0, 0, RST_ARR_BAND);
		acc(0, OBJ_ARR_DWELL, 0, 0, {16'h0, RST_ARR_DWELL});
		foreach (ro[i])
			acc(1, ro[i], 32'h5, 1, 0);
		acc(0, 16'h6069, 0, 1, 0);
		acc(1, OBJ_LAG_LIMIT, 32'h8000_0000, 1, 0);
		acc(0, OBJ_LAG_LIMIT, 0, 0, RST_LAG_LIMIT);
		acc(1, OBJ_LAG_LIMIT, MAX_LAG_LIMIT, 0, 0);
		acc(0, OBJ_LAG_LIMIT, 0, 0, MAX_LAG_LIMIT);
		$display("test regs done");
	endtask

	task automatic t_scale;
		fac_num = 32'h2;
		i_pwn_partner.set_enc(1001);
		cmd_pos = -7;
		cyc(8);
		acc(0, OBJ_MEAS_POS, 0, 0, 32'd500);
		acc(0, OBJ_MEAS_INT, 0, 0, 32'd1001);
		acc(0, OBJ_CMD_POS, 0, 0, -32'sd7);
		i_pwn_partner.set_enc(-1001);
		cyc(8);
		acc(0, OBJ_MEAS_POS, 0, 0, -32'sd500);
		fac_div = 32'h3;
		cyc(8);
		acc(0, OBJ_MEAS_POS, 0, 0, -32'sd1501);
		i_pwn_partner.set_enc(1001);
		cyc(8);
		acc(0, OBJ_MEAS_POS, 0, 0, 32'sd1501);
		fac_div = 32'h1;
		fac_num = 32'h1;
		cmd_pos = 0;
		$display("test scale done");
	endtask

	task automatic t_speed;
		i_pwn_partner.set_enc(100);
		cyc(8);
		check("speed gain", speed_cmd, -32'sd150);
		acc(0, OBJ_SPEED, 0, 0, -32'sd150);
		cmd_pos = 30;
		cyc(8);
		check("speed err", speed_cmd, -32'sd105);
		speed_limit = 32'd40;
		cyc(8);
		check("speed clamp neg", speed_cmd, -32'sd40);
		i_pwn_partner.set_enc(-100);
		cyc(8);
		check("speed clamp pos", speed_cmd, 32'sd40);
		speed_limit = 32'd1000;
		loop_gain = 16'h0100;
		cyc(8);
		check("speed unit gain", speed_cmd, 32'sd130);
		loop_gain = 16'h0180;
		cmd_pos = 0;
		i_pwn_partner.set_enc(0);
		$display("test speed done");
	endtask

	task automatic t_lag;
		int n;
		acc(1, OBJ_LAG_LIMIT, 32'd100, 0, 0);
		acc(1, OBJ_LAG_TMO, 32'd3, 0, 0);
		i_pwn_partner.set_enc(-101);
		cyc(10);
		i_pwn_partner.set_enc(0);
		wait_bit(BIT_LAG_FAULT, 1, 40, n);
		check("lag short", 32'(n), 32'd40);
		i_pwn_partner.set_enc(101);
		cyc(15);
		check("lag early", {31'h0, status_bits[BIT_LAG_FAULT]}, 32'h0);
		wait_bit(BIT_LAG_FAULT, 1, 30, n);
		check("lag set", {31'h0, status_bits[BIT_LAG_FAULT]}, 32'h1);
		check("lag out", {31'h0, lag_fault}, 32'h1);
		i_pwn_partner.set_enc(100);
		wait_bit(BIT_LAG_FAULT, 0, 6, n);
		check("lag clear", {31'h0, status_bits[BIT_LAG_FAULT]}, 32'h0);
		i_pwn_partner.set_enc(0);
		$display("test lag done");
	endtask

	task automatic t_arrive;
		int n;
		acc(1, OBJ_ARR_BAND, 32'd5, 0, 0);
		acc(1, OBJ_ARR_DWELL, 32'd4, 0, 0);
		target_pos = 0;
		i_pwn_partner.set_enc(6);
		cyc(60);
		check("arr outside", {31'h0, status_bits[BIT_ARRIVED]}, 32'h0);
		i_pwn_partner.set_enc(-5);
		cyc(25);
		check("arr early", {31'h0, status_bits[BIT_ARRIVED]}, 32'h0);
		wait_bit(BIT_ARRIVED, 1, 30, n);
		check("arr set", {31'h0, status_bits[BIT_ARRIVED]}, 32'h1);
		check("arr out", {31'h0, arrived}, 32'h1);
		i_pwn_partner.set_enc(-6);
		wait_bit(BIT_ARRIVED, 0, 5, n);
		check("arr clear", {31'h0, status_bits[BIT_ARRIVED]}, 32'h0);
		$display("test arrive done");
	endtask

	initial begin
		sys_clk_i = 0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end

	initial begin
		resetn_i = 0;
		cmd_pos = 0;
		target_pos = 32'sh0001_0000;
		fac_num = 32'h1;
		fac_div = 32'h1;
		loop_gain = 16'h0180;
		speed_limit = 32'd1000;
		repeat (12) @(posedge sys_clk_i);
		#1;
		resetn_i = 1;
		t_regs;
		t_scale;
		t_speed;
		t_lag;
		t_arrive;
		results;
	end
endmodule
`default_nettype wire
